// ---- inc/b2s_map.svh ----
`ifndef B2S_MAP_SVH
`define B2S_MAP_SVH

// ------------------------------------------------------------
// organisation
// ------------------------------------------------------------
`define B2S_WORD_W 18
`define B2S_LANE_W 9
`define B2S_LANES 2
`define B2S_ADDR_W 20
`define B2S_FIFO_DEPTH 16

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define B2S_DATA_RST 18'h00000
`define B2S_LANE_IDLE 2'h3

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define B2S_SYS_PERIOD_PS 8000
`define B2S_IMP_PERIOD 1024
`define B2S_LOOP_STRETCH_NS 30
`define B2S_LOOP_MIN_MHZ 80
`define B2S_LOOP_LOCK_EDGES 16
`define B2S_LOOP_STRETCH_CYC ((`B2S_LOOP_STRETCH_NS * 1000) / `B2S_SYS_PERIOD_PS)
`define B2S_LOOP_MIN_PER_CYC ((1000000 / `B2S_LOOP_MIN_MHZ) / `B2S_SYS_PERIOD_PS)

`endif

// ---- inc/b2s_pkg.sv ----
package b2s_pkg;

  // phase of the second write word capture
  typedef enum logic [0:0] {
    WR_IDLE,
    WR_WORD1
  } b2s_wr_phase_t;

  // which burst word a queued read entry carries
  typedef enum logic [0:0] {
    RD_FIRST,
    RD_SECOND
  } b2s_rd_word_t;

endpackage

// ---- core/b2s_fifo.sv ----
`timescale 1ns/1ps
module b2s_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rp_q];

  function automatic logic [AW-1:0] b2s_next(input logic [AW-1:0] p);
    b2s_next = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= b2s_next(wp_q);
      end
      if (pop) begin
        rp_q <= b2s_next(rp_q);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule

// ---- core/b2s_sram.sv ----
`timescale 1ns/1ps
`include "b2s_map.svh"

// Behaviour
// (R01) accesses start at input_edge_pos rise; inputs sampled on input clock rises
// (R02) write data captured on rises of both input clocks
// (R03) read data launched on output clock rises, input clocks in single-clock mode
// (R04) request, direction and address registered only at input_edge_pos rise
// (R05) every access moves two 18-bit words
// (R06) read: request low, read_not_write high; address latched, lsb to counter
// (R07) second word address is first with its lsb complemented
// (R08) first word after next input_edge_pos rise, second on following output rise
// (R09) first word at negative output edge of t+1, second at positive of t+2
// (R10) bursts always complete; a read may start on every input_edge_pos rise
// (R11) after deselected reads, outputs float after next positive output clock rise
// (R12) write: request low, read_not_write low; address latched, lsb to counter
// (R13) first word at next input_edge_pos rise, second at next input_edge_neg rise
// (R14) controller presents write words at t+1 positive and negative edges
// (R15) writes may issue every cycle; data accepted on every input edge
// (R16) deselected writes finish, then inputs are ignored
// (R17) lane selects sampled per word; deasserted lanes keep stored bytes
// (R18) single-clock mode strapped by both output clocks high at power-on
// (R19) controller inserts a NOP between a read and a following write
// (R20) a write followed by reads stays posted until the next write command
// (R21) read of the just-written address returns the posted data
// (R22) each bank gets its own request line; other controls may be shared
// (R23) output impedance updated once every 1024 cycles
// (R24) free-running echo strobes follow output clocks, or input clocks in single mode
// (R25) loop runs from 80 MHz, disabled by loop_disable_n low, reset by long cycles
// (R26) powers up deselected with data outputs floating
module b2s_sram #(
  parameter int ADDR_W = `B2S_ADDR_W,
  parameter int FIFO_DEPTH = `B2S_FIFO_DEPTH,
  parameter int IMP_PERIOD = `B2S_IMP_PERIOD,
  parameter int LOCK_EDGES = `B2S_LOOP_LOCK_EDGES
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic input_edge_pos,
  input wire logic input_edge_neg,
  input wire logic output_timing_ref_pos,
  input wire logic output_timing_ref_neg,
  input wire logic transfer_request_n,
  input wire logic read_not_write,
  input wire logic [`B2S_LANES-1:0] byte_lane_selects_n,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [`B2S_WORD_W-1:0] data_in,
  output logic [`B2S_WORD_W-1:0] data_out,
  output logic data_oe,
  output logic returned_strobe_pos,
  output logic returned_strobe_neg,
  input wire logic loop_disable_n,
  input wire logic impedance_tune_pin,
  output logic impedance_code,
  output logic impedance_update,
  output logic loop_locked,
  output logic single_clock_mode
);

  localparam int WW = `B2S_WORD_W;
  localparam int NL = `B2S_LANES;
  localparam int LW = `B2S_LANE_W;
  localparam int PW = 8 + NL + ADDR_W + WW;
  localparam int STRETCH_CYC = (`B2S_LOOP_STRETCH_CYC < 1) ? 1 : `B2S_LOOP_STRETCH_CYC;
  localparam int MINPER_CYC = (`B2S_LOOP_MIN_PER_CYC < 1) ? 1 : `B2S_LOOP_MIN_PER_CYC;

  // ------------------------------------------------------------
  // reset release and pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] rst_sync_q;
  wire rst_n = rst_sync_q[1];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  wire [PW-1:0] pin_raw = {input_edge_pos, input_edge_neg, output_timing_ref_pos, output_timing_ref_neg,
    transfer_request_n, read_not_write, loop_disable_n, impedance_tune_pin, byte_lane_selects_n, addr_in, data_in};
  logic [PW-1:0] pin_s1_q;
  logic [PW-1:0] pin_s2_q;
  logic [3:0] clk_prev_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      clk_prev_q <= 4'h0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      clk_prev_q <= pin_s2_q[PW-1 -: 4];
    end
  end

  wire [3:0] clk_lvl = pin_s2_q[PW-1 -: 4];
  wire [3:0] clk_rise = clk_lvl & ~clk_prev_q;
  wire k_rise = clk_rise[3]; // R01
  wire kn_rise = clk_rise[2]; // R02
  wire req_n_s = pin_s2_q[PW-5];
  wire rnw_s = pin_s2_q[PW-6];
  wire loop_dis_n_s = pin_s2_q[PW-7];
  wire imp_pin_s = pin_s2_q[PW-8];
  wire [NL-1:0] bws_n_s = pin_s2_q[NL+ADDR_W+WW-1 -: NL];
  wire [ADDR_W-1:0] addr_s = pin_s2_q[ADDR_W+WW-1 -: ADDR_W];
  wire [WW-1:0] din_s = pin_s2_q[WW-1:0];

  // ------------------------------------------------------------
  // single-clock strap, caught once after reset release
  // ------------------------------------------------------------
  logic strap_done_q;
  logic single_q;
  logic [1:0] strap_wait_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_q <= 1'b0;
      single_q <= 1'b0;
      strap_wait_q <= 2'h0;
    end else if (!strap_done_q) begin
      strap_wait_q <= strap_wait_q + 2'h1;
      if (strap_wait_q == 2'h3) begin
        strap_done_q <= 1'b1;
        single_q <= clk_lvl[1] && clk_lvl[0]; // R18
      end
    end
  end

  assign single_clock_mode = single_q;
  wire out_pos_rise = single_q ? clk_rise[3] : clk_rise[1]; // R03
  wire out_neg_rise = single_q ? clk_rise[2] : clk_rise[0]; // R03
  wire out_pos_lvl = single_q ? clk_lvl[3] : clk_lvl[1];
  wire out_neg_lvl = single_q ? clk_lvl[2] : clk_lvl[0];

  // ------------------------------------------------------------
  // array, burst addressing and lane merge
  // ------------------------------------------------------------
  logic [WW-1:0] mem [2**ADDR_W];

  function automatic logic [ADDR_W-1:0] b2s_second(input logic [ADDR_W-1:0] a);
    b2s_second = {a[ADDR_W-1:1], ~a[0]}; // R07
  endfunction

  function automatic logic [WW-1:0] b2s_merge(input logic [WW-1:0] old_w, input logic [WW-1:0] new_w,
                                              input logic [NL-1:0] lanes_n);
    b2s_merge = old_w;
    for (int i = 0; i < NL; i++) begin
      if (!lanes_n[i]) begin
        b2s_merge[i*LW +: LW] = new_w[i*LW +: LW]; // R17
      end
    end
  endfunction

  // ------------------------------------------------------------
  // command decode at input_edge_pos rise
  // ------------------------------------------------------------
  wire cmd_rd = k_rise && !req_n_s && rnw_s; // R06
  wire cmd_wr = k_rise && !req_n_s && !rnw_s; // R12

  // ------------------------------------------------------------
  // write path: capture two words, post, commit
  // ------------------------------------------------------------
  logic wr_cmd_q;
  logic [ADDR_W-1:0] wr_addr_q;
  b2s_pkg::b2s_wr_phase_t wr_ph_q;
  logic [ADDR_W-1:0] wcap_addr_q;
  logic [WW-1:0] wcap_w0_q;
  logic [NL-1:0] wcap_b0_q;
  logic post_v_q;
  logic [ADDR_W-1:0] post_addr_q;
  logic [WW-1:0] post_w0_q;
  logic [WW-1:0] post_w1_q;
  logic [NL-1:0] post_b0_q;
  logic [NL-1:0] post_b1_q;

  wire cap_w0 = k_rise && wr_cmd_q; // R13 R15
  wire cap_w1 = kn_rise && (wr_ph_q == b2s_pkg::WR_WORD1); // R13
  // posted entry goes to the array at a write command or when a newer one replaces it
  wire commit = post_v_q && (cmd_wr || cap_w1); // R20

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_cmd_q <= 1'b0;
      wr_addr_q <= '0;
      wr_ph_q <= b2s_pkg::WR_IDLE;
      wcap_addr_q <= '0;
      wcap_w0_q <= `B2S_DATA_RST;
      wcap_b0_q <= `B2S_LANE_IDLE;
    end else begin
      if (k_rise) begin
        wr_cmd_q <= cmd_wr; // R04
        wr_addr_q <= addr_s;
      end
      if (cap_w0) begin
        wcap_addr_q <= wr_addr_q;
        wcap_w0_q <= din_s;
        wcap_b0_q <= bws_n_s; // R17
        wr_ph_q <= b2s_pkg::WR_WORD1;
      end else if (cap_w1) begin
        wr_ph_q <= b2s_pkg::WR_IDLE; // R16
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      post_v_q <= 1'b0;
      post_addr_q <= '0;
      post_w0_q <= `B2S_DATA_RST;
      post_w1_q <= `B2S_DATA_RST;
      post_b0_q <= `B2S_LANE_IDLE;
      post_b1_q <= `B2S_LANE_IDLE;
    end else if (cap_w1) begin
      post_v_q <= 1'b1; // R20
      post_addr_q <= wcap_addr_q;
      post_w0_q <= wcap_w0_q;
      post_b0_q <= wcap_b0_q;
      post_w1_q <= din_s; // R02
      post_b1_q <= bws_n_s;
    end else if (commit) begin
      post_v_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (commit) begin
      mem[post_addr_q] <= b2s_merge(mem[post_addr_q], post_w0_q, post_b0_q); // R05
      mem[b2s_second(post_addr_q)] <= b2s_merge(mem[b2s_second(post_addr_q)], post_w1_q, post_b1_q);
    end
  end

  // ------------------------------------------------------------
  // read path: fetch at next input_edge_pos rise, queue two words
  // ------------------------------------------------------------
  logic rd_cmd_q;
  logic [ADDR_W-1:0] rd_addr_q;
  logic push_v_q;
  b2s_pkg::b2s_rd_word_t push_sel_q;
  logic [WW-1:0] fetch_w0_q;
  logic [WW-1:0] fetch_w1_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WW:0] fifo_out_data;
  logic pop;

  wire fetch = k_rise && rd_cmd_q && !push_v_q; // R08
  wire hit = post_v_q && (post_addr_q == rd_addr_q); // R21
  wire [WW-1:0] arr_w0 = mem[rd_addr_q];
  wire [WW-1:0] arr_w1 = mem[b2s_second(rd_addr_q)];
  wire [WW-1:0] rd_w0 = hit ? b2s_merge(arr_w0, post_w0_q, post_b0_q) : arr_w0; // R21
  wire [WW-1:0] rd_w1 = hit ? b2s_merge(arr_w1, post_w1_q, post_b1_q) : arr_w1;
  wire push_ok = push_v_q && fifo_in_ready;
  wire [WW:0] push_data = (push_sel_q == b2s_pkg::RD_FIRST) ? {1'b0, fetch_w0_q} : {1'b1, fetch_w1_q};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_cmd_q <= 1'b0;
      rd_addr_q <= '0;
      push_v_q <= 1'b0;
      push_sel_q <= b2s_pkg::RD_FIRST;
      fetch_w0_q <= `B2S_DATA_RST;
      fetch_w1_q <= `B2S_DATA_RST;
    end else begin
      if (fetch) begin
        fetch_w0_q <= rd_w0;
        fetch_w1_q <= rd_w1;
        push_v_q <= 1'b1;
        push_sel_q <= b2s_pkg::RD_FIRST;
      end else if (push_ok) begin
        push_sel_q <= b2s_pkg::RD_SECOND;
        push_v_q <= (push_sel_q == b2s_pkg::RD_FIRST); // R10
      end
      if (k_rise && (!rd_cmd_q || fetch)) begin
        rd_cmd_q <= cmd_rd; // R06
        rd_addr_q <= addr_s;
      end
    end
  end

  b2s_fifo #(
    .WIDTH(WW + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_rd_fifo (
    .clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(push_v_q),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data)
  );

  // ------------------------------------------------------------
  // output launch: first word on negative edge, second on positive
  // ------------------------------------------------------------
  wire pop_first = fifo_out_valid && !fifo_out_data[WW] && out_neg_rise; // R09
  wire pop_second = fifo_out_valid && fifo_out_data[WW] && out_pos_rise; // R09
  assign pop = pop_first || pop_second;
  wire more_pending = fifo_out_valid || push_v_q || rd_cmd_q;
  logic [WW-1:0] dout_q;
  logic oe_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_q <= `B2S_DATA_RST;
      oe_q <= 1'b0; // R26
    end else begin
      if (pop) begin
        dout_q <= fifo_out_data[WW-1:0]; // R03
        oe_q <= 1'b1;
      end else if (out_pos_rise && !more_pending) begin
        oe_q <= 1'b0; // R11
      end
    end
  end

  assign data_out = dout_q;
  assign data_oe = oe_q;

  // ------------------------------------------------------------
  // echo strobes
  // ------------------------------------------------------------
  logic echo_pos_q;
  logic echo_neg_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      echo_pos_q <= 1'b0;
      echo_neg_q <= 1'b0;
    end else begin
      echo_pos_q <= out_pos_lvl; // R24
      echo_neg_q <= out_neg_lvl; // R24
    end
  end

  assign returned_strobe_pos = echo_pos_q;
  assign returned_strobe_neg = echo_neg_q;

  // ------------------------------------------------------------
  // impedance update every IMP_PERIOD input clock cycles
  // ------------------------------------------------------------
  logic [$clog2(IMP_PERIOD)-1:0] imp_cnt_q;
  logic imp_upd_q;
  logic imp_code_q;
  wire imp_wrap = k_rise && (imp_cnt_q == ($clog2(IMP_PERIOD))'(IMP_PERIOD - 1));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      imp_cnt_q <= '0;
      imp_upd_q <= 1'b0;
      imp_code_q <= 1'b0;
    end else begin
      imp_upd_q <= imp_wrap; // R23
      if (imp_wrap) begin
        imp_cnt_q <= '0;
        imp_code_q <= imp_pin_s;
      end else if (k_rise) begin
        imp_cnt_q <= imp_cnt_q + 1'b1;
      end
    end
  end

  assign impedance_update = imp_upd_q;
  assign impedance_code = imp_code_q;

  // ------------------------------------------------------------
  // delay-locked loop model: period watch, disable and reset
  // ------------------------------------------------------------
  logic [7:0] per_cnt_q;
  logic [7:0] lock_cnt_q;
  logic locked_q;
  wire stretched = (per_cnt_q > 8'(STRETCH_CYC)); // R25
  wire too_slow = k_rise && (per_cnt_q >= 8'(MINPER_CYC));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt_q <= 8'h00;
      lock_cnt_q <= 8'h00;
      locked_q <= 1'b0;
    end else begin
      if (k_rise) begin
        per_cnt_q <= 8'h00;
      end else if (per_cnt_q != 8'hff) begin
        per_cnt_q <= per_cnt_q + 8'h01;
      end
      if (!loop_dis_n_s || stretched) begin
        lock_cnt_q <= 8'h00; // R25
        locked_q <= 1'b0;
      end else if (too_slow) begin
        lock_cnt_q <= 8'h00;
      end else if (k_rise && !locked_q) begin
        lock_cnt_q <= lock_cnt_q + 8'h01;
        locked_q <= (lock_cnt_q == 8'(LOCK_EDGES - 1));
      end
    end
  end

  assign loop_locked = locked_q;

endmodule

// ---- sim/b2s_sram_asserts.sv ----
`timescale 1ns/1ps
module b2s_sram_asserts #(
  parameter int IMP_PERIOD = 1024
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic input_edge_pos,
  input wire logic output_timing_ref_pos,
  input wire logic output_timing_ref_neg,
  input wire logic data_oe,
  input wire logic returned_strobe_pos,
  input wire logic returned_strobe_neg,
  input wire logic loop_disable_n,
  input wire logic loop_locked,
  input wire logic impedance_update,
  input wire logic single_clock_mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ----
  // input clock rises counted between impedance updates
  // ----
  logic k_q;
  logic seen_q;
  logic [15:0] kcnt_q;
  logic [15:0] kcnt_d;
  logic k_rise;
  assign k_rise = input_edge_pos & ~k_q;
  assign kcnt_d = impedance_update ? {15'h0000, k_rise} : kcnt_q + {15'h0000, k_rise};
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      k_q <= 1'b0;
      seen_q <= 1'b0;
      kcnt_q <= 16'h0000;
    end else begin
      k_q <= input_edge_pos;
      seen_q <= seen_q | impedance_update;
      kcnt_q <= kcnt_d;
    end
  end
  // ----
  // properties
  // ----
  property p_imp_cnt;
    impedance_update && seen_q |-> kcnt_q == IMP_PERIOD;
  endproperty
  a_imp_cnt: assert property (p_imp_cnt) else $error("update spacing wrong");
  property p_imp_gap;
    impedance_update |=> !impedance_update [*8];
  endproperty
  a_imp_gap: assert property (p_imp_gap) else $error("update repeats");
  property p_strobe_pos;
    $rose(output_timing_ref_pos) && !single_clock_mode |-> ##[1:6] returned_strobe_pos;
  endproperty
  a_strobe_pos: assert property (p_strobe_pos) else $error("pos strobe missing");
  property p_strobe_neg;
    $rose(output_timing_ref_neg) && !single_clock_mode |-> ##[1:6] returned_strobe_neg;
  endproperty
  a_strobe_neg: assert property (p_strobe_neg) else $error("neg strobe missing");
  property p_oe_rise;
    $rose(data_oe) |-> $past(output_timing_ref_neg, 2);
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("first word off neg clock");
  property p_oe_fall;
    $fell(data_oe) |-> $past(output_timing_ref_pos, 2);
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("float off pos clock");
  property p_rst_quiet;
    $rose(resetn) |-> !data_oe && !returned_strobe_pos ##1 !data_oe;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("not idle after reset");
  property p_strap_hold;
    $past(resetn, 8) |-> $stable(single_clock_mode);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed");
  property p_loop_off;
    !loop_disable_n [*4] |-> !loop_locked;
  endproperty
  a_loop_off: assert property (p_loop_off) else $error("loop locked while off");
endmodule
bind b2s_sram b2s_sram_asserts #(.IMP_PERIOD(IMP_PERIOD)) u_chk (
  .sys_clk(sys_clk),
  .resetn(resetn),
  .input_edge_pos(input_edge_pos),
  .output_timing_ref_pos(output_timing_ref_pos),
  .output_timing_ref_neg(output_timing_ref_neg),
  .data_oe(data_oe),
  .returned_strobe_pos(returned_strobe_pos),
  .returned_strobe_neg(returned_strobe_neg),
  .loop_disable_n(loop_disable_n),
  .loop_locked(loop_locked),
  .impedance_update(impedance_update),
  .single_clock_mode(single_clock_mode)
);

// ---- sim/b2s_host_model.sv ----
`timescale 1ns/1ps
module b2s_host_model (
  input wire logic strap,
  output logic k,
  output logic kn,
  output logic c,
  output logic cn
);
  // ----
  // free-running clock pairs, phase unrelated to sys_clk
  // ----
  initial begin
    k = 1'b0;
    #3.1;
    forever #32 k = ~k;
  end
  assign kn = ~k;
  // zero-skew output pair; strap holds both high for single-clock mode
  assign c = k | strap;
  assign cn = ~k | strap;
endmodule

// ---- sim/b2s_sram_test.sv ----
`timescale 1ns/1ps
module b2s_sram_test;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic k, kn, c, cn;
  logic transfer_request_n = 1'b1;
  logic read_not_write = 1'b1;
  logic [1:0] byte_lane_selects_n = 2'h3;
  logic [5:0] addr_in = 6'h00;
  logic [17:0] data_in = 18'h00000;
  logic loop_disable_n = 1'b1;
  logic strap = 1'b0;
  logic impedance_tune_pin = 1'b0;
  logic [17:0] data_out;
  logic data_oe, returned_strobe_pos, returned_strobe_neg;
  logic impedance_code, impedance_update, loop_locked, single_clock_mode;
  int error_cnt = 0;
  int n_compared = 0;
  logic [17:0] mem [64];
  logic [17:0] exp_q [$];
  logic wr_pend = 1'b0;
  logic [5:0] wa = 6'h00;
  localparam logic [17:0] J = 18'h3ffff;

  always #4 sys_clk = ~sys_clk;
  b2s_host_model host (.strap(strap), .k(k), .kn(kn), .c(c), .cn(cn));
  b2s_sram #(.ADDR_W(6), .FIFO_DEPTH(16), .IMP_PERIOD(8), .LOCK_EDGES(4)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .input_edge_pos(k), .input_edge_neg(kn),
    .output_timing_ref_pos(c), .output_timing_ref_neg(cn), .transfer_request_n(transfer_request_n),
    .read_not_write(read_not_write), .byte_lane_selects_n(byte_lane_selects_n), .addr_in(addr_in),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .returned_strobe_pos(returned_strobe_pos),
    .returned_strobe_neg(returned_strobe_neg), .loop_disable_n(loop_disable_n),
    .impedance_tune_pin(impedance_tune_pin), .impedance_code(impedance_code),
    .impedance_update(impedance_update), .loop_locked(loop_locked), .single_clock_mode(single_clock_mode));
  // ----
  // helpers
  // ----
  task automatic chk(input logic [17:0] got, input logic [17:0] want);
    n_compared++;
    if (got !== want) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic go();
    @(posedge sys_clk);
    #1;
  endtask
  function automatic logic [17:0] merge(input logic [17:0] o, input logic [17:0] w, input logic [1:0] l);
    merge = o;
    if (!l[0]) merge[8:0] = w[8:0];
    if (!l[1]) merge[17:9] = w[17:9];
  endfunction
  // one input clock cycle: command for this rise, words for the write begun before
  task automatic cyc(input logic rq, input logic rw, input logic [5:0] a,
      input logic [17:0] w0, input logic [1:0] l0, input logic [17:0] w1, input logic [1:0] l1);
    @(negedge k);
    go();
    transfer_request_n = rq;
    read_not_write = rw;
    addr_in = a;
    data_in = w0;
    byte_lane_selects_n = l0;
    if (wr_pend) begin
      mem[wa] = merge(mem[wa], w0, l0);
      mem[wa ^ 6'h01] = merge(mem[wa ^ 6'h01], w1, l1);
    end
    wr_pend = !rq && !rw;
    wa = a;
    if (!rq && rw) begin
      exp_q.push_back(mem[a]);
      exp_q.push_back(mem[a ^ 6'h01]);
    end
    @(posedge k);
    repeat (2) go();
    data_in = w1;
    byte_lane_selects_n = l1;
  endtask
  // deselect, then collect queued read words one half cycle apart
  task automatic rx();
    int n;
    n = 0;
    @(negedge k);
    go();
    transfer_request_n = 1'b1;
    while (data_oe !== 1'b1 && n < 64) begin
      go();
      n++;
    end
    chk(18'(n < 64), 18'h00001);
    while (exp_q.size() > 0) begin
      chk(data_out, exp_q.pop_front());
      repeat (4) go();
    end
    chk(18'(data_oe), 18'h00001);
    repeat (6) go();
    chk(18'(data_oe), 18'h00000);
  endtask
  // ----
  // scenarios
  // ----
  // echo strobes sampled shortly after an input clock rise
  task automatic echo_chk();
    @(posedge k);
    repeat (4) go();
    chk(18'(returned_strobe_pos), 18'h00001);
    chk(18'(returned_strobe_neg), 18'h00000);
  endtask
  task automatic s_reset();
    chk(18'(data_oe), 18'h00000);
    chk(18'(single_clock_mode), 18'h00000);
    echo_chk();
  endtask
  // mid-run reset with the output clocks strapped high
  task automatic s_single();
    go();
    resetn = 1'b0;
    strap = 1'b1;
    repeat (4) go();
    resetn = 1'b1;
    repeat (20) go();
    chk(18'(data_oe), 18'h00000);
    chk(18'(single_clock_mode), 18'h00001);
    echo_chk();
    cyc(1'b0, 1'b0, 6'h0c, J, 2'h0, J, 2'h0);
    cyc(1'b1, 1'b1, 6'h00, 18'h12345, 2'h0, 18'h0fedc, 2'h0);
    cyc(1'b0, 1'b1, 6'h0c, J, 2'h0, J, 2'h0);
    rx();
  endtask
  task automatic s_b2b();
    cyc(1'b0, 1'b0, 6'h04, J, 2'h0, J, 2'h0);
    cyc(1'b0, 1'b0, 6'h08, 18'h11111, 2'h0, 18'h22222, 2'h0);
    cyc(1'b1, 1'b1, 6'h00, 18'h13579, 2'h0, 18'h2468a, 2'h0);
    cyc(1'b0, 1'b1, 6'h04, J, 2'h0, J, 2'h0);
    cyc(1'b0, 1'b1, 6'h08, J, 2'h0, J, 2'h0);
    rx();
  endtask
  task automatic s_lanes();
    cyc(1'b0, 1'b0, 6'h05, J, 2'h0, J, 2'h0);
    cyc(1'b1, 1'b1, 6'h00, 18'h00000, 2'h2, J, 2'h1);
    cyc(1'b0, 1'b1, 6'h05, J, 2'h0, J, 2'h0);
    rx();
  endtask
  task automatic s_bypass();
    cyc(1'b0, 1'b0, 6'h09, J, 2'h0, J, 2'h0);
    cyc(1'b0, 1'b1, 6'h09, 18'h0abcd, 2'h0, 18'h3cafe, 2'h0);
    rx();
    cyc(1'b0, 1'b0, 6'h02, J, 2'h0, J, 2'h0);
    cyc(1'b1, 1'b1, 6'h00, 18'h00777, 2'h0, 18'h00888, 2'h0);
    cyc(1'b0, 1'b1, 6'h08, J, 2'h0, J, 2'h0);
    rx();
  endtask
  task automatic s_imp();
    int p;
    p = 0;
    go();
    impedance_tune_pin = 1'b1;
    repeat (64) go();
    repeat (128) begin
      go();
      p += impedance_update;
    end
    chk(18'(p), 18'h00002);
    chk(18'(impedance_code), 18'h00001);
  endtask
  task automatic s_loop();
    go();
    loop_disable_n = 1'b0;
    repeat (8) go();
    chk(18'(loop_locked), 18'h00000);
    loop_disable_n = 1'b1;
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    repeat (20) go();
    s_reset();
    s_b2b();
    s_lanes();
    s_bypass();
    s_imp();
    s_loop();
    s_single();
    end_sim();
  end
endmodule
